// file: core/ppm_top.sv
// pin multiplexer for the parallel port and both serial ports, with apb registers
//
// Operation
// - all routing comes from one select register
// - parallel field three bits, modes zero to six
// - control pins carry spi in modes 1, 6
// - data 2..7 become gpio 12..17 in 1, 6
// - data 8..11: lcd, gpio, spi or audio 2
// - data 12..15: lcd, gpio, uart or audio 3
// - serial port 1 field: card, audio, gpio
// - port 1 audio mode: data 2, 3 gpio
// - serial port 0 field: card, audio, gpio
// - port 0 audio mode: data 2, 3 gpio
// - data 2..15 pulldowns in third inhibit register
// - serial pin pulldowns in first, mode independent
// - edge rate select for memory and clock pins
`timescale 1ns/1ps
module ppm_top
  import ppm_pkg::*;
#(
  parameter int unsigned ADDR_W = 16, // apb address width
  parameter int unsigned PP_PINS = 21, // parallel-port pins
  parameter int unsigned SP_PINS = 12 // both serial-port groups
)
(
  input wire logic clk_in, // system clock
  input wire logic rst_in, // asynchronous reset, active high
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [ADDR_W-1:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  input wire logic [3:0] pstrb_in, // apb byte strobes
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error
  input wire logic [20:0] lcd_o_in, // lcd bridge pin outputs
  input wire logic [20:0] lcd_oe_in, // lcd bridge pin enables
  output logic [20:0] lcd_i_out, // lcd bridge pin inputs
  input wire logic [6:0] spi_o_in, // spi clk, rx, tx, cs0..cs3
  input wire logic [6:0] spi_oe_in, // spi enables
  output logic [6:0] spi_i_out, // spi inputs
  input wire logic [3:0] uart_o_in, // uart rts, cts, rxd, txd
  input wire logic [3:0] uart_oe_in, // uart enables
  output logic [3:0] uart_i_out, // uart inputs
  input wire logic [3:0] aud2_o_in, // audio port 2 clk, fs, rx, dx
  input wire logic [3:0] aud2_oe_in, // audio port 2 enables
  output logic [3:0] aud2_i_out, // audio port 2 inputs
  input wire logic [3:0] aud3_o_in, // audio port 3 clk, fs, rx, dx
  input wire logic [3:0] aud3_oe_in, // audio port 3 enables
  output logic [3:0] aud3_i_out, // audio port 3 inputs
  input wire logic [31:0] gpio_o_in, // general io outputs
  input wire logic [31:0] gpio_oe_in, // general io enables
  output logic [31:0] gpio_i_out, // general io inputs
  input wire logic [5:0] card0_o_in, // card port 0 clk, cmd, d0..d3
  input wire logic [5:0] card0_oe_in, // card port 0 enables
  output logic [5:0] card0_i_out, // card port 0 inputs
  input wire logic [3:0] aud0_o_in, // audio port 0 clk, fs, dx, rx
  input wire logic [3:0] aud0_oe_in, // audio port 0 enables
  output logic [3:0] aud0_i_out, // audio port 0 inputs
  input wire logic [5:0] card1_o_in, // card port 1 clk, cmd, d0..d3
  input wire logic [5:0] card1_oe_in, // card port 1 enables
  output logic [5:0] card1_i_out, // card port 1 inputs
  input wire logic [3:0] aud1_o_in, // audio port 1 clk, fs, dx, rx
  input wire logic [3:0] aud1_oe_in, // audio port 1 enables
  output logic [3:0] aud1_i_out, // audio port 1 inputs
  output logic [20:0] pp_pin_o_out, // parallel pins, driven level
  output logic [20:0] pp_pin_oe_out, // parallel pins, driver enable
  input wire logic [20:0] pp_pin_i_in, // parallel pins, seen level
  output logic [5:0] sp0_pin_o_out, // serial port 0 pins, level
  output logic [5:0] sp0_pin_oe_out, // serial port 0 pins, enable
  input wire logic [5:0] sp0_pin_i_in, // serial port 0 pins, seen
  output logic [5:0] sp1_pin_o_out, // serial port 1 pins, level
  output logic [5:0] sp1_pin_oe_out, // serial port 1 pins, enable
  input wire logic [5:0] sp1_pin_i_in, // serial port 1 pins, seen
  output logic [13:0] pp_data_pd_en_out, // pulldown on lcd data 2..15
  output logic [5:0] sp0_pd_en_out, // pulldown on serial port 0 pins
  output logic [5:0] sp1_pd_en_out, // pulldown on serial port 1 pins
  output logic slew_slow_emif_out, // slow edges on memory pins
  output logic slew_slow_cko_out // slow edges on clock output pin
);
  // ==========================================================
  // helper functions
  // byte-lane merge of the low halfword, then writable mask
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0] strb,
                                             input logic [15:0] wmask);
    logic [15:0] merged;
    merged = {strb[1] ? wd[15:8] : old_v[15:8], strb[0] ? wd[7:0] : old_v[7:0]};
    return merged & wmask;
  endfunction

  // which parallel-port group a pin belongs to
  function automatic logic [1:0] pp_grp(input int unsigned pin);
    if (pin >= 3 && pin <= 8)
      return GRP_LOW;
    else if (pin >= 9 && pin <= 12)
      return GRP_MID;
    else if (pin >= 13 && pin <= 16)
      return GRP_HIGH;
    else
      return GRP_CTRL;
  endfunction

  // parallel-port owner: {defined, slot}
  function automatic logic [2:0] pp_pick(input ppm_pp_mode_t mode, input logic [1:0] grp);
    logic [2:0] r;
    r = {1'b1, SLOT_PRI};
    if (mode == PP_BAD)
      r = 3'h0;
    else
      case (grp)
        GRP_CTRL, GRP_LOW:
        begin
          // spi or gpio only in modes 1 and 6
          if (mode == PP_M1 || mode == PP_M6)
            r = {1'b1, (grp == GRP_CTRL) ? SLOT_ALT_A : SLOT_GPIO};
        end
        GRP_MID:
        begin
          case (mode)
            PP_M0: r = {1'b1, SLOT_PRI};
            PP_M2: r = {1'b1, SLOT_GPIO};
            PP_M3, PP_M5: r = {1'b1, SLOT_ALT_A};
            default: r = {1'b1, SLOT_ALT_B};
          endcase
        end
        default:
        begin
          case (mode)
            PP_M0: r = {1'b1, SLOT_PRI};
            PP_M2: r = {1'b1, SLOT_GPIO};
            PP_M3, PP_M6: r = {1'b1, SLOT_ALT_B};
            default: r = {1'b1, SLOT_ALT_A};
          endcase
        end
      endcase
    return r;
  endfunction

  // serial-port owner: {defined, slot}; data 2 and 3 have no audio role
  function automatic logic [2:0] sp_pick(input ppm_sp_mode_t mode, input logic data23);
    logic [2:0] r;
    case (mode)
      SP_CARD: r = {1'b1, SLOT_PRI};
      SP_AUDIO: r = {1'b1, data23 ? SLOT_GPIO : SLOT_ALT_A};
      SP_GPIO: r = {1'b1, SLOT_GPIO};
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // registers
  logic [15:0] sel_r; // external bus select, the only routing source
  logic [15:0] rate_r; // output edge rate
  logic [15:0] pdinh1_r; // pulldown inhibit, serial pins
  logic [15:0] pdinh3_r; // pulldown inhibit, parallel data pins
  logic ready_r; // access phase answer
  logic err_r; // unmapped access seen in setup
  logic [31:0] rdata_r; // captured read data

  // ==========================================================
  // apb decode
  wire apb_setup; // first cycle of a transfer
  wire apb_commit; // edge at which a write takes effect
  wire hit_sel;
  wire hit_rate;
  wire hit_pdinh1;
  wire hit_pdinh3;
  wire hit_status;
  wire addr_ok;
  wire [15:0] status_v; // undefined-code flags
  wire [15:0] rd_mux; // register selected for read
  assign apb_setup = psel_in & ~penable_in;
  assign apb_commit = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
  assign hit_sel = (paddr_in == ADDR_W'(ADDR_SEL));
  assign hit_rate = (paddr_in == ADDR_W'(ADDR_RATE));
  assign hit_pdinh1 = (paddr_in == ADDR_W'(ADDR_PDINH1));
  assign hit_pdinh3 = (paddr_in == ADDR_W'(ADDR_PDINH3));
  assign hit_status = (paddr_in == ADDR_W'(ADDR_STATUS));
  assign addr_ok = hit_sel | hit_rate | hit_pdinh1 | hit_pdinh3 | hit_status;
  assign rd_mux = hit_sel ? sel_r :
                  hit_rate ? rate_r :
                  hit_pdinh1 ? pdinh1_r :
                  hit_pdinh3 ? pdinh3_r :
                  hit_status ? status_v : 16'h0000;

  // current modes, straight from the one select register
  ppm_pp_mode_t pp_mode_q;
  ppm_sp_mode_t sp1_mode_q;
  ppm_sp_mode_t sp0_mode_q;
  assign pp_mode_q = ppm_pp_mode_t'(sel_r[PP_LSB +: 3]);
  assign sp1_mode_q = ppm_sp_mode_t'(sel_r[SP1_LSB +: 2]);
  assign sp0_mode_q = ppm_sp_mode_t'(sel_r[SP0_LSB +: 2]);
  assign status_v = {13'h0000, sp0_mode_q == SP_BAD, sp1_mode_q == SP_BAD,
                     pp_mode_q == PP_BAD};

  // apb answer: one wait-free access phase after every setup
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ready_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ready_r <= apb_setup;
      err_r <= apb_setup & ~addr_ok;
      if (apb_setup && !pwrite_in)
        rdata_r <= {16'h0000, rd_mux};
    end
  end
  assign pready_out = ready_r;
  assign pslverr_out = ready_r & err_r;
  assign prdata_out = rdata_r;

  // register writes; status is read only
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sel_r <= SEL_RST;
      rate_r <= RATE_RST;
      pdinh1_r <= PDINH_RST;
      pdinh3_r <= PDINH_RST;
    end
    else if (apb_commit)
    begin
      if (hit_sel)
        sel_r <= lane_merge(sel_r, pwdata_in, pstrb_in, SEL_WMASK);
      if (hit_rate)
        rate_r <= lane_merge(rate_r, pwdata_in, pstrb_in, RATE_WMASK);
      if (hit_pdinh1)
        pdinh1_r <= lane_merge(pdinh1_r, pwdata_in, pstrb_in, PDINH1_WMASK);
      if (hit_pdinh3)
        pdinh3_r <= lane_merge(pdinh3_r, pwdata_in, pstrb_in, PDINH3_WMASK);
    end
  end

  // ==========================================================
  // pulldown and edge rate outputs; an inhibit bit of one turns the pulldown off
  assign pp_data_pd_en_out = ~pdinh3_r[PD3_LSB +: 14];
  assign sp0_pd_en_out = ~pdinh1_r[SP0_PD_LSB +: 6];
  assign sp1_pd_en_out = ~pdinh1_r[SP1_PD_LSB +: 6];
  assign slew_slow_emif_out = rate_r[SLEW_EMIF_BIT];
  assign slew_slow_cko_out = rate_r[SLEW_CKO_BIT];

  // ==========================================================
  // parallel-port source slots, one bit per pin
  wire [20:0] pp_s1_o;
  wire [20:0] pp_s1_oe;
  wire [20:0] pp_s2_o;
  wire [20:0] pp_s2_oe;
  wire [20:0] pp_s3_o;
  wire [20:0] pp_s3_oe;
  wire [20:0] pp_d0;
  wire [20:0] pp_d1;
  wire [20:0] pp_d2;
  wire [20:0] pp_d3;
  // gpio: data 2..7 -> 12..17, 8..11 -> 18,19,20,27, 12..15 -> 28..31
  assign pp_s1_o = {4'h0, gpio_o_in[31:27], gpio_o_in[20:12], 3'h0};
  assign pp_s1_oe = {4'h0, gpio_oe_in[31:27], gpio_oe_in[20:12], 3'h0};
  // alt a: spi on control pins and data 8..11, uart on data 12..15
  assign pp_s2_o = {spi_o_in[6:3], uart_o_in, spi_o_in[2], spi_o_in[1], spi_o_in[3],
                    spi_o_in[0], 6'h00, spi_o_in[2:0]};
  assign pp_s2_oe = {spi_oe_in[6:3], uart_oe_in, spi_oe_in[2], spi_oe_in[1], spi_oe_in[3],
                     spi_oe_in[0], 6'h00, spi_oe_in[2:0]};
  // alt b: audio 2 on data 8..11, audio 3 on data 12..15
  assign pp_s3_o = {4'h0, aud3_o_in, aud2_o_in, 9'h000};
  assign pp_s3_oe = {4'h0, aud3_oe_in, aud2_oe_in, 9'h000};

  for (genvar gi = 0; gi < PP_PINS; gi++)
  begin : g_pp
    wire [2:0] pick;
    wire [3:0] di;
    assign pick = pp_pick(pp_mode_q, pp_grp(gi));
    ppm_pin_cell u_cell (
      .sel_ok_in(pick[2]),
      .sel_in(pick[1:0]),
      .src_o_in({pp_s3_o[gi], pp_s2_o[gi], pp_s1_o[gi], lcd_o_in[gi]}),
      .src_oe_in({pp_s3_oe[gi], pp_s2_oe[gi], pp_s1_oe[gi], lcd_oe_in[gi]}),
      .pin_i_in(pp_pin_i_in[gi]),
      .pin_o_out(pp_pin_o_out[gi]),
      .pin_oe_out(pp_pin_oe_out[gi]),
      .dst_i_out(di)
    );
    assign pp_d0[gi] = di[0];
    assign pp_d1[gi] = di[1];
    assign pp_d2[gi] = di[2];
    assign pp_d3[gi] = di[3];
  end

  // ==========================================================
  // serial-port groups, port 1 above port 0
  wire [11:0] sp_s0_o;
  wire [11:0] sp_s0_oe;
  wire [11:0] sp_s2_o;
  wire [11:0] sp_s2_oe;
  wire [11:0] sp_pin_i;
  wire [11:0] sp_pin_o;
  wire [11:0] sp_pin_oe;
  wire [11:0] sp_d0;
  wire [11:0] sp_d1;
  wire [11:0] sp_d2;
  assign sp_s0_o = {card1_o_in, card0_o_in};
  assign sp_s0_oe = {card1_oe_in, card0_oe_in};
  assign sp_s2_o = {2'h0, aud1_o_in, 2'h0, aud0_o_in};
  assign sp_s2_oe = {2'h0, aud1_oe_in, 2'h0, aud0_oe_in};
  assign sp_pin_i = {sp1_pin_i_in, sp0_pin_i_in};

  for (genvar gs = 0; gs < SP_PINS; gs++)
  begin : g_sp
    wire [2:0] pick;
    wire [3:0] di;
    assign pick = sp_pick((gs < 6) ? sp0_mode_q : sp1_mode_q, (gs % 6) >= 4);
    ppm_pin_cell u_cell (
      .sel_ok_in(pick[2]),
      .sel_in(pick[1:0]),
      .src_o_in({1'b0, sp_s2_o[gs], gpio_o_in[gs], sp_s0_o[gs]}),
      .src_oe_in({1'b0, sp_s2_oe[gs], gpio_oe_in[gs], sp_s0_oe[gs]}),
      .pin_i_in(sp_pin_i[gs]),
      .pin_o_out(sp_pin_o[gs]),
      .pin_oe_out(sp_pin_oe[gs]),
      .dst_i_out(di)
    );
    assign sp_d0[gs] = di[0];
    assign sp_d1[gs] = di[1];
    assign sp_d2[gs] = di[2];
  end
  assign {sp1_pin_o_out, sp0_pin_o_out} = sp_pin_o;
  assign {sp1_pin_oe_out, sp0_pin_oe_out} = sp_pin_oe;

  // ==========================================================
  // inputs back to peripherals; unrouted inputs read low
  assign lcd_i_out = pp_d0;
  assign spi_i_out = {pp_d2[20:18], pp_d2[17] | pp_d2[10], pp_d2[2] | pp_d2[12],
                      pp_d2[1] | pp_d2[11], pp_d2[0] | pp_d2[9]};
  assign uart_i_out = pp_d2[16:13];
  assign aud2_i_out = pp_d3[12:9];
  assign aud3_i_out = pp_d3[16:13];
  assign gpio_i_out = {pp_d1[16:12], 6'h00, pp_d1[11:3], sp_d1};
  assign card0_i_out = sp_d0[5:0];
  assign card1_i_out = sp_d0[11:6];
  assign aud0_i_out = sp_d2[3:0];
  assign aud1_i_out = sp_d2[9:6];

  // ==========================================================
  // checks
  sequence s_sel_wr;
    psel_in && penable_in && pready_out && pwrite_in && hit_sel && pstrb_in[1];
  endsequence
  sequence s_full_wr;
    psel_in && penable_in && pready_out && pwrite_in && (pstrb_in == 4'hf);
  endsequence

  property p_sel_wr;
    @(posedge clk_in) disable iff (rst_in)
      s_sel_wr |=> (pp_mode_q == $past(pwdata_in[14:12]));
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("route field not taken");

  property p_ctrl;
    @(posedge clk_in) disable iff (rst_in)
      ((pp_mode_q == PP_M1 || pp_mode_q == PP_M6) |->
        pp_pin_o_out[0] == spi_o_in[0] && pp_pin_oe_out[20] == spi_oe_in[6]) and
      ((pp_mode_q == PP_M4) |-> pp_pin_o_out[17] == lcd_o_in[17]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control pin routing wrong");

  property p_low;
    @(posedge clk_in) disable iff (rst_in)
      (pp_mode_q == PP_M6) |-> pp_pin_o_out[3] == gpio_o_in[12] &&
        gpio_i_out[17] == pp_pin_i_in[8] && lcd_i_out[3] == 1'b0;
  endproperty
  a_low: assert property (p_low) else $error("data 2..7 routing wrong");

  property p_mid;
    @(posedge clk_in) disable iff (rst_in)
      ((pp_mode_q == PP_M2) |-> pp_pin_o_out[12] == gpio_o_in[27]) and
      ((pp_mode_q == PP_M3) |-> pp_pin_o_out[10] == spi_o_in[3]) and
      ((pp_mode_q == PP_M4) |-> aud2_i_out[2] == pp_pin_i_in[11]);
  endproperty
  a_mid: assert property (p_mid) else $error("data 8..11 routing wrong");

  property p_high;
    @(posedge clk_in) disable iff (rst_in)
      ((pp_mode_q == PP_M5) |-> pp_pin_o_out[16] == uart_o_in[3]) and
      ((pp_mode_q == PP_M3) |-> pp_pin_oe_out[13] == aud3_oe_in[0]);
  endproperty
  a_high: assert property (p_high) else $error("data 12..15 routing wrong");

  property p_sp1;
    @(posedge clk_in) disable iff (rst_in)
      (sp1_mode_q == SP_AUDIO) |-> sp1_pin_o_out[2] == aud1_o_in[2] &&
        sp1_pin_o_out[5] == gpio_o_in[11] && card1_i_out == 6'h00;
  endproperty
  a_sp1: assert property (p_sp1) else $error("serial port 1 routing wrong");

  property p_sp0;
    @(posedge clk_in) disable iff (rst_in)
      (sp0_mode_q == SP_AUDIO) |-> sp0_pin_o_out[3] == aud0_o_in[3] &&
        gpio_i_out[4] == sp0_pin_i_in[4] && aud0_i_out[1] == sp0_pin_i_in[1];
  endproperty
  a_sp0: assert property (p_sp0) else $error("serial port 0 routing wrong");

  property p_undef;
    @(posedge clk_in) disable iff (rst_in)
      (pp_mode_q == PP_BAD) |-> pp_pin_oe_out == 21'h000000 && lcd_i_out == 21'h000000;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined mode drives pins");

  property p_pd3;
    @(posedge clk_in) disable iff (rst_in)
      (s_full_wr and hit_pdinh3) |=> pp_data_pd_en_out == ~$past(pwdata_in[15:2]);
  endproperty
  a_pd3: assert property (p_pd3) else $error("data pulldown not updated");

  property p_pd1;
    @(posedge clk_in) disable iff (rst_in)
      s_sel_wr |=> $stable(sp0_pd_en_out) && $stable(sp1_pd_en_out);
  endproperty
  a_pd1: assert property (p_pd1) else $error("mode change moved a pulldown");

  property p_slew;
    @(posedge clk_in) disable iff (rst_in)
      (s_full_wr and hit_rate) |=> slew_slow_emif_out == $past(pwdata_in[1]) ##1
        $stable(slew_slow_emif_out) || $past(apb_commit);
  endproperty
  a_slew: assert property (p_slew) else $error("edge rate not held");
endmodule

// file: core/ppm_pkg.sv
// shared constants and types of the peripheral pin multiplexer
package ppm_pkg;
  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [15:0] IDX_SEL = 16'h1c00; // external bus select
  localparam logic [15:0] IDX_RATE = 16'h1c16; // output edge rate
  localparam logic [15:0] IDX_PDINH1 = 16'h1c17; // pulldown inhibit first
  localparam logic [15:0] IDX_PDINH3 = 16'h1c19; // pulldown inhibit third
  localparam logic [15:0] IDX_STATUS = 16'h1c1a; // routing status
  localparam logic [15:0] ADDR_SEL = 16'h7000;
  localparam logic [15:0] ADDR_RATE = 16'h7058;
  localparam logic [15:0] ADDR_PDINH1 = 16'h705c;
  localparam logic [15:0] ADDR_PDINH3 = 16'h7064;
  localparam logic [15:0] ADDR_STATUS = 16'h7068;
  // ==========================================================
  // field layout
  localparam int unsigned PP_LSB = 12; // parallel port route field
  localparam int unsigned SP1_LSB = 10; // serial port 1 route field
  localparam int unsigned SP0_LSB = 8; // serial port 0 route field
  localparam logic [15:0] SEL_WMASK = 16'h7f00;
  localparam logic [15:0] RATE_WMASK = 16'h0003;
  localparam logic [15:0] PDINH1_WMASK = 16'h0fff;
  localparam logic [15:0] PDINH3_WMASK = 16'hfffc;
  localparam int unsigned SLEW_CKO_BIT = 0;
  localparam int unsigned SLEW_EMIF_BIT = 1;
  localparam int unsigned SP0_PD_LSB = 0;
  localparam int unsigned SP1_PD_LSB = 6;
  localparam int unsigned PD3_LSB = 2;
  // ==========================================================
  // reset values
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [15:0] PDINH_RST = 16'h0000;
  // ==========================================================
  // mode codes
  typedef enum logic [2:0] {
    PP_M0 = 3'h0, PP_M1 = 3'h1, PP_M2 = 3'h2, PP_M3 = 3'h3,
    PP_M4 = 3'h4, PP_M5 = 3'h5, PP_M6 = 3'h6, PP_BAD = 3'h7
  } ppm_pp_mode_t;
  typedef enum logic [1:0] {
    SP_CARD = 2'h0, SP_AUDIO = 2'h1, SP_GPIO = 2'h2, SP_BAD = 2'h3
  } ppm_sp_mode_t;
  // ==========================================================
  // source slots of one pin cell
  localparam logic [1:0] SLOT_PRI = 2'h0;
  localparam logic [1:0] SLOT_GPIO = 2'h1;
  localparam logic [1:0] SLOT_ALT_A = 2'h2;
  localparam logic [1:0] SLOT_ALT_B = 2'h3;
  // parallel-port pin groups
  localparam logic [1:0] GRP_CTRL = 2'h0;
  localparam logic [1:0] GRP_LOW = 2'h1;
  localparam logic [1:0] GRP_MID = 2'h2;
  localparam logic [1:0] GRP_HIGH = 2'h3;
endpackage

// file: core/ppm_pin_cell.sv
// one shared pin: picks one of four sources and returns the pin level
`timescale 1ns/1ps
module ppm_pin_cell
  import ppm_pkg::*;
(
  input wire logic sel_ok_in, // selection is a defined code
  input wire logic [1:0] sel_in, // slot that owns the pin
  input wire logic [3:0] src_o_in, // output level per slot
  input wire logic [3:0] src_oe_in, // output enable per slot
  input wire logic pin_i_in, // level seen on the pin
  output logic pin_o_out, // level driven to the pin
  output logic pin_oe_out, // pin driver enable
  output logic [3:0] dst_i_out // pin level returned to the owner only
);
  // ==========================================================
  // one-hot owner; an undefined code owns nothing
  wire [3:0] owner;
  assign owner = sel_ok_in ? (4'h1 << sel_in) : 4'h0;
  // ==========================================================
  // output side: only the owner drives
  assign pin_o_out = |(src_o_in & owner);
  assign pin_oe_out = |(src_oe_in & owner);
  // input side: non-owners see a quiet low
  assign dst_i_out = owner & {4{pin_i_in}};
endmodule

// file: sim/ppm_pin_model.sv
// board side of the shared pins: driven pins echo, released pins follow pulls
`timescale 1ns/1ps
module ppm_pin_model
(
  input wire logic [20:0] pp_o_in,
  input wire logic [20:0] pp_oe_in,
  input wire logic [13:0] pp_pd_in,
  output logic [20:0] pp_i_out,
  input wire logic [5:0] sp0_o_in,
  input wire logic [5:0] sp0_oe_in,
  input wire logic [5:0] sp0_pd_in,
  output logic [5:0] sp0_i_out,
  input wire logic [5:0] sp1_o_in,
  input wire logic [5:0] sp1_oe_in,
  input wire logic [5:0] sp1_pd_in,
  output logic [5:0] sp1_i_out
);
  // a released pin reads 0 under its pulldown, else the board pullup gives 1
  assign pp_i_out = (pp_oe_in & pp_o_in) | (~pp_oe_in & ~{4'h0, pp_pd_in, 3'h0});
  assign sp0_i_out = (sp0_oe_in & sp0_o_in) | (~sp0_oe_in & ~sp0_pd_in);
  assign sp1_i_out = (sp1_oe_in & sp1_o_in) | (~sp1_oe_in & ~sp1_pd_in);
endmodule

// file: sim/tb_top.sv
// self-checking bench of the peripheral pin multiplexer
`timescale 1ns/1ps
module tb_top;
  import ppm_pkg::*;
  logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic pready_out, pslverr_out, er, slew_slow_emif_out, slew_slow_cko_out;
  logic [15:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, rd, en = '1, gpio_o_in = 32'h1c35_a0f6;
  logic [20:0] lcd_o_in = 21'h0f0f0f, lcd_i_out, pp_pin_o_out, pp_pin_oe_out, pp_pin_i_in;
  logic [6:0] spi_o_in = 7'h55;
  logic [3:0] uart_o_in = 4'ha, aud2_o_in = 4'h3, aud3_o_in = 4'h5;
  logic [3:0] aud0_o_in = 4'h9, aud1_o_in = 4'h6;
  logic [5:0] card0_o_in = 6'h2a, card1_o_in = 6'h15, sp0_pin_o_out, sp0_pin_oe_out;
  logic [5:0] sp0_pin_i_in, sp1_pin_o_out, sp1_pin_oe_out, sp1_pin_i_in;
  logic [5:0] sp0_pd_en_out, sp1_pd_en_out;
  logic [13:0] pp_data_pd_en_out;
  int error_cnt = 0, checks = 0;
  ppm_top ppm_top_inst (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in(4'hf), .prdata_out, .pready_out, .pslverr_out, .lcd_o_in,
    .lcd_oe_in(en[20:0]), .lcd_i_out, .spi_o_in, .spi_oe_in(en[6:0]), .spi_i_out(),
    .uart_o_in, .uart_oe_in(en[3:0]), .uart_i_out(), .aud2_o_in, .aud2_oe_in(en[3:0]),
    .aud2_i_out(), .aud3_o_in, .aud3_oe_in(en[3:0]), .aud3_i_out(), .gpio_o_in,
    .gpio_oe_in(en), .gpio_i_out(), .card0_o_in, .card0_oe_in(en[5:0]), .card0_i_out(),
    .aud0_o_in, .aud0_oe_in(en[3:0]), .aud0_i_out(), .card1_o_in, .card1_oe_in(en[5:0]),
    .card1_i_out(), .aud1_o_in, .aud1_oe_in(en[3:0]), .aud1_i_out(), .pp_pin_o_out,
    .pp_pin_oe_out, .pp_pin_i_in, .sp0_pin_o_out, .sp0_pin_oe_out, .sp0_pin_i_in,
    .sp1_pin_o_out, .sp1_pin_oe_out, .sp1_pin_i_in, .pp_data_pd_en_out, .sp0_pd_en_out,
    .sp1_pd_en_out, .slew_slow_emif_out, .slew_slow_cko_out);
  ppm_pin_model ppm_pin_model_inst (.pp_o_in(pp_pin_o_out), .pp_oe_in(pp_pin_oe_out),
    .pp_pd_in(pp_data_pd_en_out), .pp_i_out(pp_pin_i_in), .sp0_o_in(sp0_pin_o_out),
    .sp0_oe_in(sp0_pin_oe_out), .sp0_pd_in(sp0_pd_en_out), .sp0_i_out(sp0_pin_i_in),
    .sp1_o_in(sp1_pin_o_out), .sp1_oe_in(sp1_pin_oe_out), .sp1_pd_in(sp1_pd_en_out),
    .sp1_i_out(sp1_pin_i_in));
  always #4 clk_in = ~clk_in;
  // =====================================================
  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  // one apb transfer; routing settles just after the committing edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    #1;
  endtask
  // =====================================================
  // parallel port: every mode, then the undefined code
  task automatic t_pp;
    logic [3:0] e;
    for (int m = 0; m < 8; m++)
    begin
      apb(1'b1, ADDR_SEL, {17'h0, m[2:0], 12'h000}); // peripherals stay idle
      case (m)
        0: e = {lcd_o_in[13], lcd_o_in[9], lcd_o_in[3], lcd_o_in[0]};
        1: e = {uart_o_in[0], aud2_o_in[0], gpio_o_in[12], spi_o_in[0]};
        2: e = {gpio_o_in[28], gpio_o_in[18], lcd_o_in[3], lcd_o_in[0]};
        3: e = {aud3_o_in[0], spi_o_in[0], lcd_o_in[3], lcd_o_in[0]};
        4: e = {uart_o_in[0], aud2_o_in[0], lcd_o_in[3], lcd_o_in[0]};
        5: e = {uart_o_in[0], spi_o_in[0], lcd_o_in[3], lcd_o_in[0]};
        6: e = {aud3_o_in[0], aud2_o_in[0], gpio_o_in[12], spi_o_in[0]};
        default: e = 4'h0;
      endcase
      chk("pp pins", e, {pp_pin_o_out[13], pp_pin_o_out[9], pp_pin_o_out[3], pp_pin_o_out[0]});
    end
    chk("pp oe bad", 32'h0, pp_pin_oe_out);
    chk("lcd in bad", 32'h0, lcd_i_out);
    apb(1'b1, ADDR_SEL, 32'h0);
    chk("lcd echo", lcd_o_in, lcd_i_out);
    @(posedge clk_in);
    en <= '0;
    #1;
    chk("pp oe off", 32'h0, pp_pin_oe_out);
    @(posedge clk_in);
    en <= '1;
    $display("test parallel done");
  endtask
  // both serial ports, all codes
  task automatic t_sp;
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, ADDR_SEL, {20'h0, m[1:0], m[1:0], 8'h00});
      if (m < 3)
      begin
        chk("sp0 p0", m == 0 ? card0_o_in[0] : m == 1 ? aud0_o_in[0] : gpio_o_in[0], sp0_pin_o_out[0]);
        chk("sp0 p4", m == 0 ? card0_o_in[4] : gpio_o_in[4], sp0_pin_o_out[4]);
        chk("sp1 p0", m == 0 ? card1_o_in[0] : m == 1 ? aud1_o_in[0] : gpio_o_in[6], sp1_pin_o_out[0]);
        chk("sp1 p4", m == 0 ? card1_o_in[4] : gpio_o_in[10], sp1_pin_o_out[4]);
      end
      else
        chk("sp oe bad", 32'h0, {sp1_pin_oe_out, sp0_pin_oe_out});
    end
    $display("test serial done");
  endtask
  // pulldowns, edge rate and an unmapped address
  task automatic t_regs;
    chk("pd3 reset", 32'h3fff, pp_data_pd_en_out);
    apb(1'b1, ADDR_PDINH1, 32'h0000_0fc1);
    apb(1'b1, ADDR_PDINH3, 32'h0000_0004);
    apb(1'b1, ADDR_RATE, 32'h0000_0003);
    chk("sp pd", 32'h03e, {sp1_pd_en_out, sp0_pd_en_out});
    chk("pp pd", 32'h3ffe, pp_data_pd_en_out);
    chk("slew", 32'h3, {slew_slow_emif_out, slew_slow_cko_out});
    apb(1'b0, ADDR_RATE, 32'h0);
    chk("slew rd", 32'h3, rd);
    apb(1'b0, 16'h7100, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    $display("test registers done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_pp;
    t_sp;
    wrap_up;
  end
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up;
  end
endmodule
